/* core/dac_ctrl_pkg.sv */
// constants for the dac configuration word and channel monitor decoder
//
// Contract
// RL1 - bit 11 sets powered-down output state
// RL2 - bit 10 picks internal reference level
// RL3 - bit 9 turns amplifier current boost on
// RL4 - bit 8 picks internal or external reference
// RL5 - bit 7 enables monitor, else three-stated
// RL6 - bit 6 enables over-temperature amplifier shutdown
// RL7 - soft power-up re-enables only when cool
// RL8 - bits 5 and 4 have no function
// RL9 - bits 3..0 enable toggle per group
// RL10 - load strobe flips enabled channels between A/B
// RL11 - monitor select: command address 01010, code bits 11..6
// RL12 - host enables monitor before selecting a channel
// RL13 - codes 0-31 dac, 34-37 aux inputs
// RL14 - code 63 three-states the monitor output
// RL15 - config word read/written at command address 01100
// RL16 - soft power-up command powers the amplifiers
// RL17 - undefined monitor codes three-state the output
// RL18 - read returns last write, bits 5:4 zero
`default_nettype none
package dac_ctrl_pkg;
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  localparam logic [1:0]  REG_SEL_SPECIAL = 2'h0;
  localparam logic [4:0]  ADDR_SOFT_PD    = 5'h08;
  localparam logic [4:0]  ADDR_SOFT_PU    = 5'h09;
  localparam logic [4:0]  ADDR_MON_SEL    = 5'h0A;
  localparam logic [4:0]  ADDR_CFG        = 5'h0C;
  // ----------------------------------------------------------------
  // configuration word layout
  // ----------------------------------------------------------------
  localparam int          CFG_W           = 12;
  localparam int          BIT_PD_STATE    = 11;
  localparam int          BIT_REF_LEVEL   = 10;
  localparam int          BIT_BOOST       = 9;
  localparam int          BIT_REF_EN      = 8;
  localparam int          BIT_MON_EN      = 7;
  localparam int          BIT_THERM_EN    = 6;
  localparam int          TOGGLE_LSB      = 0;
  localparam int          NUM_GROUPS      = 4;
  localparam logic [11:0] CFG_KEEP_MASK   = 12'hFCF;
  // bit 10 reset follows the 2.5 v variant; change for the 1.25 v one
  localparam logic [11:0] CFG_RESET       = 12'hC00;
  // ----------------------------------------------------------------
  // channel monitor
  // ----------------------------------------------------------------
  localparam int          MON_CODE_MSB    = 11;
  localparam int          MON_CODE_LSB    = 6;
  localparam int          NUM_CH          = 32;
  localparam int          GROUP_SIZE      = 8;
  localparam logic [5:0]  MON_DAC_LAST    = 6'h1F;
  localparam logic [5:0]  MON_AUX_FIRST   = 6'h22;
  localparam logic [5:0]  MON_AUX_LAST    = 6'h25;
  localparam logic [5:0]  MON_CODE_OFF    = 6'h3F;
endpackage
`default_nettype wire

/* core/dac_ctrl_mon.sv */
// configuration word, power/thermal state, toggle select and monitor routing
`default_nettype none
module dac_ctrl_mon
  import dac_ctrl_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        CMD_VALID,
  input  wire logic        CMD_RW,
  input  wire logic [1:0]  CMD_REG_SEL,
  input  wire logic [4:0]  CMD_ADDR,
  input  wire logic [11:0] CMD_DATA,
  input  wire logic        LOAD_DAC_STROBE_N,
  input  wire logic        OVER_TEMP,
  output logic      [11:0] RD_DATA,
  output logic             RD_VALID,
  output logic             POWERDOWN_OUTPUT_STATE,
  output logic             INTERNAL_REF_LEVEL_SEL,
  output logic             AMP_CURRENT_BOOST,
  output logic             INTERNAL_REF_ENABLE,
  output logic             MONITOR_ENABLE,
  output logic             THERMAL_SHUTDOWN_ENABLE,
  output logic [3:0]       TOGGLE_GROUP_ENABLES,
  output logic             AMPS_POWERED,
  output logic             THERMAL_TRIPPED,
  output logic [31:0]      CHANNEL_SEL_B,
  output logic             MONITOR_OUTPUT_EN,
  output logic             MONITOR_SRC_AUX,
  output logic [4:0]       MONITOR_DAC_CHANNEL,
  output logic [1:0]       MONITOR_AUX_SEL
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] cfg;
    logic [5:0]  mon_code;
    logic        mon_oe;
    logic        mon_aux;
    logic [4:0]  mon_ch;
    logic [1:0]  mon_aux_sel;
    logic        amps_on;
    logic        therm_trip;
    logic [31:0] sel_b;
    logic [11:0] rd_data;
    logic        rd_valid;
    logic        ot_s1;
    logic        ot_s2;
    logic        ld_s1;
    logic        ld_s2;
    logic        ld_s3;
  } state_t;

  state_t st_reg;
  state_t st_next;

  localparam state_t ST_RESET = '{
    cfg:         CFG_RESET,
    mon_code:    MON_CODE_OFF,
    mon_oe:      1'b0,
    mon_aux:     1'b0,
    mon_ch:      5'h00,
    mon_aux_sel: 2'h0,
    amps_on:     1'b1,
    therm_trip:  1'b0,
    sel_b:       32'h0000_0000,
    rd_data:     12'h000,
    rd_valid:    1'b0,
    ot_s1:       1'b0,
    ot_s2:       1'b0,
    ld_s1:       1'b1,
    ld_s2:       1'b1,
    ld_s3:       1'b1
  };

  // ----------------------------------------------------------------
  // decoding shared by logic and checks
  // ----------------------------------------------------------------
  function automatic logic is_cmd(input logic [1:0] rs, input logic [4:0] a,
                                  input logic [4:0] want);
    return (rs == REG_SEL_SPECIAL) && (a == want);
  endfunction

  // only dac codes and the four aux codes route; the rest stay off
  function automatic logic mon_routable(input logic [5:0] code);
    return (code <= MON_DAC_LAST) || ((code >= MON_AUX_FIRST) && (code <= MON_AUX_LAST));
  endfunction

  logic cmd_wr;
  logic cmd_rd;
  logic cmd_cfg_wr;
  logic cmd_cfg_rd;
  logic cmd_mon;
  logic cmd_pu;
  logic cmd_pd;
  logic ld_fall;
  logic [5:0] cmd_code;

  assign cmd_wr     = CMD_VALID && !CMD_RW;
  assign cmd_rd     = CMD_VALID && CMD_RW;
  assign cmd_cfg_wr = cmd_wr && is_cmd(CMD_REG_SEL, CMD_ADDR, ADDR_CFG); // [RL15]
  assign cmd_cfg_rd = cmd_rd && is_cmd(CMD_REG_SEL, CMD_ADDR, ADDR_CFG); // [RL15]
  assign cmd_mon    = cmd_wr && is_cmd(CMD_REG_SEL, CMD_ADDR, ADDR_MON_SEL); // [RL11]
  assign cmd_pu     = cmd_wr && is_cmd(CMD_REG_SEL, CMD_ADDR, ADDR_SOFT_PU); // [RL16]
  assign cmd_pd     = cmd_wr && is_cmd(CMD_REG_SEL, CMD_ADDR, ADDR_SOFT_PD);
  // low bits of the data are not looked at
  assign cmd_code   = CMD_DATA[MON_CODE_MSB:MON_CODE_LSB]; // [RL11]
  // strobe is active low: act on the falling edge only
  assign ld_fall    = st_reg.ld_s3 && !st_reg.ld_s2;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // pins from outside pass two flops first
    st_next.ot_s1 = OVER_TEMP;
    st_next.ot_s2 = st_reg.ot_s1;
    st_next.ld_s1 = LOAD_DAC_STROBE_N;
    st_next.ld_s2 = st_reg.ld_s1;
    st_next.ld_s3 = st_reg.ld_s2;
    st_next.rd_valid = 1'b0;

    if (cmd_cfg_wr) begin
      st_next.cfg = CMD_DATA & CFG_KEEP_MASK; // [RL8] [RL18]
    end
    if (cmd_cfg_rd) begin
      st_next.rd_data  = st_reg.cfg; // [RL18]
      st_next.rd_valid = 1'b1;
    end
    // a select issued while the monitor is off is dropped
    if (cmd_mon && st_reg.cfg[BIT_MON_EN]) begin
      st_next.mon_code = cmd_code; // [RL12]
    end

    if (cmd_pd) begin
      st_next.amps_on = 1'b0;
    end
    if (cmd_pu && !(st_reg.cfg[BIT_THERM_EN] && st_reg.ot_s2)) begin
      st_next.amps_on    = 1'b1; // [RL16] [RL7]
      st_next.therm_trip = 1'b0;
    end
    // thermal trip wins over any power-up in the same cycle
    if (st_reg.cfg[BIT_THERM_EN] && st_reg.ot_s2) begin
      st_next.amps_on    = 1'b0; // [RL6]
      st_next.therm_trip = 1'b1;
    end

    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (!st_next.cfg[TOGGLE_LSB + ch / GROUP_SIZE]) begin
        st_next.sel_b[ch] = 1'b0; // [RL9]
      end else if (ld_fall) begin
        st_next.sel_b[ch] = !st_reg.sel_b[ch]; // [RL10]
      end
    end

    // routing is registered from the next code and enable
    st_next.mon_oe      = st_next.cfg[BIT_MON_EN] &&
                          mon_routable(st_next.mon_code); // [RL5] [RL14] [RL17]
    st_next.mon_aux     = st_next.mon_code > MON_DAC_LAST; // [RL13]
    st_next.mon_ch      = st_next.mon_code[4:0];
    st_next.mon_aux_sel = 2'(st_next.mon_code - MON_AUX_FIRST);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign RD_DATA                 = st_reg.rd_data;
  assign RD_VALID                = st_reg.rd_valid;
  assign POWERDOWN_OUTPUT_STATE  = st_reg.cfg[BIT_PD_STATE]; // [RL1]
  assign INTERNAL_REF_LEVEL_SEL  = st_reg.cfg[BIT_REF_LEVEL]; // [RL2]
  assign AMP_CURRENT_BOOST       = st_reg.cfg[BIT_BOOST]; // [RL3]
  assign INTERNAL_REF_ENABLE     = st_reg.cfg[BIT_REF_EN]; // [RL4]
  assign MONITOR_ENABLE          = st_reg.cfg[BIT_MON_EN]; // [RL5]
  assign THERMAL_SHUTDOWN_ENABLE = st_reg.cfg[BIT_THERM_EN]; // [RL6]
  assign TOGGLE_GROUP_ENABLES    = st_reg.cfg[TOGGLE_LSB +: NUM_GROUPS]; // [RL9]
  assign AMPS_POWERED            = st_reg.amps_on;
  assign THERMAL_TRIPPED         = st_reg.therm_trip;
  assign CHANNEL_SEL_B           = st_reg.sel_b;
  assign MONITOR_OUTPUT_EN       = st_reg.mon_oe;
  assign MONITOR_SRC_AUX         = st_reg.mon_aux;
  assign MONITOR_DAC_CHANNEL     = st_reg.mon_ch;
  assign MONITOR_AUX_SEL         = st_reg.mon_aux_sel;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  property p_cfg_write;
    logic [11:0] d;
    (cmd_cfg_wr, d = CMD_DATA) |=> (st_reg.cfg == (d & CFG_KEEP_MASK));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write not stored"); // [RL15]

  property p_dont_care;
    st_reg.cfg[5:4] == 2'h0;
  endproperty
  a_dont_care: assert property (p_dont_care) else $error("bits 5:4 not zero"); // [RL8]

  property p_read_back;
    cmd_cfg_rd |=> RD_VALID && (RD_DATA == $past(st_reg.cfg))
      ##1 (RD_VALID == $past(cmd_cfg_rd));
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data wrong"); // [RL18]

  property p_mon_disabled;
    !MONITOR_ENABLE |-> !MONITOR_OUTPUT_EN;
  endproperty
  a_mon_disabled: assert property (p_mon_disabled) else $error("monitor driven while off"); // [RL5]

  property p_mon_off_code;
    cmd_mon && MONITOR_ENABLE && (cmd_code == MON_CODE_OFF) |=> !MONITOR_OUTPUT_EN;
  endproperty
  a_mon_off_code: assert property (p_mon_off_code) else $error("code 63 not off"); // [RL14]

  property p_mon_dac;
    logic [5:0] c;
    (cmd_mon && MONITOR_ENABLE && cmd_code <= MON_DAC_LAST, c = cmd_code) |=>
      MONITOR_OUTPUT_EN && !MONITOR_SRC_AUX && (MONITOR_DAC_CHANNEL == c[4:0]);
  endproperty
  a_mon_dac: assert property (p_mon_dac) else $error("dac channel not routed"); // [RL13]

  property p_mon_undef;
    cmd_mon && MONITOR_ENABLE && (cmd_code == 6'h20 || cmd_code == 6'h3E) |=>
      !MONITOR_OUTPUT_EN;
  endproperty
  a_mon_undef: assert property (p_mon_undef) else $error("undefined code drives"); // [RL17]

  property p_thermal;
    THERMAL_SHUTDOWN_ENABLE && st_reg.ot_s2 |=> !AMPS_POWERED && THERMAL_TRIPPED;
  endproperty
  a_thermal: assert property (p_thermal) else $error("no thermal shutdown"); // [RL6]

  property p_pu_hot;
    cmd_pu && THERMAL_SHUTDOWN_ENABLE && st_reg.ot_s2 |=> !AMPS_POWERED;
  endproperty
  a_pu_hot: assert property (p_pu_hot) else $error("powered up while hot"); // [RL7]

  property p_pu;
    cmd_pu && !THERMAL_SHUTDOWN_ENABLE |=> AMPS_POWERED;
  endproperty
  a_pu: assert property (p_pu) else $error("soft power-up ignored"); // [RL16]

  property p_toggle;
    ld_fall && TOGGLE_GROUP_ENABLES[0] && !cmd_cfg_wr |=>
      CHANNEL_SEL_B[7:0] == ~$past(CHANNEL_SEL_B[7:0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed"); // [RL10]

  property p_group_off;
    !TOGGLE_GROUP_ENABLES[3] |-> CHANNEL_SEL_B[31:24] == 8'h00;
  endproperty
  a_group_off: assert property (p_group_off) else $error("disabled group on b"); // [RL9]

  property p_pd_state;
    logic d;
    (cmd_cfg_wr, d = CMD_DATA[BIT_PD_STATE]) |=> (POWERDOWN_OUTPUT_STATE == d);
  endproperty
  a_pd_state: assert property (p_pd_state) else $error("power-down state bit wrong"); // [RL1]

  property p_ref_level;
    logic d;
    (cmd_cfg_wr, d = CMD_DATA[BIT_REF_LEVEL]) |=> (INTERNAL_REF_LEVEL_SEL == d);
  endproperty
  a_ref_level: assert property (p_ref_level) else $error("reference level bit wrong"); // [RL2]

  property p_boost;
    logic d;
    (cmd_cfg_wr, d = CMD_DATA[BIT_BOOST]) |=> (AMP_CURRENT_BOOST == d);
  endproperty
  a_boost: assert property (p_boost) else $error("boost bit wrong"); // [RL3]

  property p_ref_src;
    logic d;
    (cmd_cfg_wr, d = CMD_DATA[BIT_REF_EN]) |=> (INTERNAL_REF_ENABLE == d);
  endproperty
  a_ref_src: assert property (p_ref_src) else $error("reference source bit wrong"); // [RL4]

  property p_mon_aux;
    logic [5:0] c;
    (cmd_mon && MONITOR_ENABLE && cmd_code >= MON_AUX_FIRST && cmd_code <= MON_AUX_LAST,
     c = cmd_code) |=>
      MONITOR_OUTPUT_EN && MONITOR_SRC_AUX && (MONITOR_AUX_SEL == 2'(c - MON_AUX_FIRST));
  endproperty
  a_mon_aux: assert property (p_mon_aux) else $error("aux input not routed"); // [RL13]

  // a dropped select must not wake up later when the monitor is enabled
  property p_mon_dropped;
    cmd_mon && !MONITOR_ENABLE |=> $stable(st_reg.mon_code);
  endproperty
  a_mon_dropped: assert property (p_mon_dropped) else $error("select kept while off"); // [RL12]

  property p_pu_clear;
    cmd_pu && !(THERMAL_SHUTDOWN_ENABLE && st_reg.ot_s2) |=> AMPS_POWERED && !THERMAL_TRIPPED;
  endproperty
  a_pu_clear: assert property (p_pu_clear) else $error("cool power-up refused"); // [RL7]

  c_toggle:   cover property (ld_fall && TOGGLE_GROUP_ENABLES[2]);
  c_mon_aux:  cover property (MONITOR_OUTPUT_EN && MONITOR_SRC_AUX);
  c_trip:     cover property (THERMAL_TRIPPED ##1 cmd_pu);
  c_read:     cover property (cmd_cfg_wr ##[1:4] cmd_cfg_rd);

endmodule
`default_nettype wire

/* dv/dac_host_model.sv */
// host model that issues special-function commands to the control block
`default_nettype none
module dac_host_model
  import dac_ctrl_pkg::*;
(
  input  wire logic        CLK,
  output logic             CMD_VALID,
  output logic             CMD_RW,
  output logic [1:0]       CMD_REG_SEL,
  output logic [4:0]       CMD_ADDR,
  output logic [11:0]      CMD_DATA
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    CMD_VALID   = 1'b0;
    CMD_RW      = 1'b0;
    CMD_REG_SEL = 2'h3;
    CMD_ADDR    = 5'h1F;
    CMD_DATA    = 12'hFFF;
  end
  // ------------------------------------------------------------
  // command cycles
  // ------------------------------------------------------------
  // one command per call; an idle cycle follows, so valid never toggles twice in a step
  task automatic send(input logic rw, input logic [1:0] sel, input logic [4:0] addr,
                      input logic [11:0] data);
    @(posedge CLK);
    CMD_VALID   <= 1'b1;
    CMD_RW      <= rw;
    CMD_REG_SEL <= sel;
    CMD_ADDR    <= addr;
    CMD_DATA    <= data;
    @(posedge CLK);
    CMD_VALID   <= 1'b0;
    // released address and data never keep the last value; rw and reg select do
    CMD_ADDR    <= ~addr;
    CMD_DATA    <= ~data;
  endtask
  // enable goes in first, otherwise the select would be dropped
  task automatic select_monitor(input logic [11:0] cfg, input logic [5:0] code);
    send(1'b0, REG_SEL_SPECIAL, ADDR_CFG, cfg | 12'h080);
    send(1'b0, REG_SEL_SPECIAL, ADDR_MON_SEL, {code, 6'h2A});
  endtask
endmodule
`default_nettype wire

/* dv/dac_control_and_channel_monitor_bench.sv */
// self-checking bench for the dac configuration word and monitor decoder
`default_nettype none
module dac_control_and_channel_monitor_bench
  import dac_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, arst_n, strobe_n, over_temp;
  logic        cmd_valid, cmd_rw;
  logic [1:0]  cmd_reg_sel, aux_sel;
  logic [4:0]  cmd_addr, dac_ch;
  logic [11:0] cmd_data, rd_data, cfg_out;
  logic        rd_valid, pd_state, ref_lvl, boost, ref_en, mon_en, therm_en;
  logic [3:0]  toggles;
  logic        amps, tripped, mon_oe, src_aux;
  logic [31:0] sel_b;
  int          errors, num_checks;
  int          cycles = 0;
  localparam logic [5:0] CODES [9] = '{6'h00, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h25, 6'h26,
                                       6'h3E, 6'h3F};
  localparam logic       EN_EXP [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  assign cfg_out = {pd_state, ref_lvl, boost, ref_en, mon_en, therm_en, 2'b00, toggles};
  dac_host_model u_host (.CLK(clk), .CMD_VALID(cmd_valid), .CMD_RW(cmd_rw),
    .CMD_REG_SEL(cmd_reg_sel), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data));
  dac_ctrl_mon u_dut (.CLK(clk), .ARST_N(arst_n), .CMD_VALID(cmd_valid), .CMD_RW(cmd_rw),
    .CMD_REG_SEL(cmd_reg_sel), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data),
    .LOAD_DAC_STROBE_N(strobe_n), .OVER_TEMP(over_temp), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .POWERDOWN_OUTPUT_STATE(pd_state), .INTERNAL_REF_LEVEL_SEL(ref_lvl),
    .AMP_CURRENT_BOOST(boost), .INTERNAL_REF_ENABLE(ref_en), .MONITOR_ENABLE(mon_en),
    .THERMAL_SHUTDOWN_ENABLE(therm_en), .TOGGLE_GROUP_ENABLES(toggles), .AMPS_POWERED(amps),
    .THERMAL_TRIPPED(tripped), .CHANNEL_SEL_B(sel_b), .MONITOR_OUTPUT_EN(mon_oe),
    .MONITOR_SRC_AUX(src_aux), .MONITOR_DAC_CHANNEL(dac_ch), .MONITOR_AUX_SEL(aux_sel));
  // ------------------------------------------------------------
  // clock, reset, timeout
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // whole run is under two hundred cycles; the ceiling leaves a wide margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg_wr(input logic [11:0] d);
    u_host.send(1'b0, REG_SEL_SPECIAL, ADDR_CFG, d);
    #1;
  endtask
  task automatic special_cmd(input logic [4:0] a);
    u_host.send(1'b0, REG_SEL_SPECIAL, a, 12'h000);
    #1;
  endtask
  // low and high phases of four cycles each, well past the two-flop sync
  task automatic pulse();
    @(posedge clk);
    strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    strobe_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    strobe_n = 1'b1;
    over_temp = 1'b0;
    errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk(cfg_out, CFG_RESET);
    chk({amps, tripped, mon_oe, rd_valid}, 4'h8);
    chk(sel_b, 32'h0);
    $display("test reset done");
    u_host.send(1'b0, REG_SEL_SPECIAL, ADDR_MON_SEL, 12'h000);
    #1;
    chk(mon_oe, 1'b0);
    // enabling afterwards must not route the code that was sent while off
    cfg_wr(12'h080);
    chk(mon_oe, 1'b0);
    for (int i = 0; i < 9; i++) begin
      u_host.select_monitor(12'h000, CODES[i]);
      #1;
      chk(mon_oe, EN_EXP[i]);
      if (CODES[i] < 6'h20) chk({src_aux, dac_ch}, {1'b0, CODES[i][4:0]});
      else if (EN_EXP[i]) chk({src_aux, aux_sel}, {1'b1, 2'(CODES[i] - 6'h22)});
    end
    $display("test monitor rows done");
    u_host.select_monitor(12'h000, 6'h05);
    cfg_wr(12'h000);
    chk(mon_oe, 1'b0);
    cfg_wr(12'hFFF);
    chk(cfg_out, 12'hFCF);
    u_host.send(1'b1, REG_SEL_SPECIAL, ADDR_CFG, 12'h000);
    #1;
    chk({rd_valid, rd_data}, 13'h1FCF);
    @(posedge clk);
    #1;
    chk(rd_valid, 1'b0);
    cfg_wr(12'h000);
    u_host.send(1'b0, 2'h1, ADDR_CFG, 12'hFFF);
    #1;
    chk(cfg_out, 12'h000);
    $display("test config word done");
    cfg_wr(12'h005);
    pulse();
    chk(sel_b, 32'h00FF00FF);
    pulse();
    chk(sel_b, 32'h0);
    cfg_wr(12'h00F);
    pulse();
    chk(sel_b, 32'hFFFFFFFF);
    cfg_wr(12'h000);
    chk(sel_b, 32'h0);
    $display("test toggle done");
    @(posedge clk);
    over_temp <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk({amps, tripped}, 2'h2);
    cfg_wr(12'h040);
    repeat (6) @(posedge clk);
    #1;
    chk({amps, tripped}, 2'h1);
    special_cmd(ADDR_SOFT_PU);
    chk({amps, tripped}, 2'h1);
    @(posedge clk);
    over_temp <= 1'b0;
    repeat (6) @(posedge clk);
    special_cmd(ADDR_SOFT_PU);
    chk({amps, tripped}, 2'h2);
    special_cmd(ADDR_SOFT_PD);
    chk(amps, 1'b0);
    special_cmd(ADDR_SOFT_PU);
    chk(amps, 1'b1);
    // leave the amplifiers off so the reset below has something to restore
    special_cmd(ADDR_SOFT_PD);
    $display("test power done");
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(cfg_out, CFG_RESET);
    chk({amps, tripped, mon_oe, rd_valid}, 4'h8);
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(cfg_out, CFG_RESET);
    cfg_wr(12'h0C0);
    chk(cfg_out, 12'h0C0);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
